// [verilog/upr_pkg.sv]
// Package for the USB power, frame, token and descriptor page register slice.
// Assumes a single 40 MHz clock and a simple strobe register port.
`default_nettype none
package upr_pkg;
    // **********************************************
    // Register offsets (byte addresses, word index = addr/4)
    // **********************************************
    localparam logic [7:0] UPR_OFF_POWER = 8'h00;
    localparam logic [7:0] UPR_OFF_FRAME = 8'h04;
    localparam logic [7:0] UPR_OFF_TOKEN = 8'h08;
    localparam logic [7:0] UPR_OFF_PAGE_MID = 8'h0c;
    localparam logic [7:0] UPR_OFF_PAGE_TOP = 8'h10;
    localparam logic [7:0] UPR_OFF_IRQ_STATUS = 8'h14;
    localparam logic [7:0] UPR_OFF_IRQ_MASK = 8'h18;
    // **********************************************
    // Field positions
    // **********************************************
    localparam int UPR_BIT_POWER = 0;
    localparam int UPR_BIT_SUSPEND = 1;
    localparam int UPR_BIT_BUSY = 3;
    localparam int UPR_BIT_GUARD = 4;
    localparam int UPR_BIT_PENDING = 7;
    localparam int UPR_IRQ_ACTIVITY = 0;
    localparam int UPR_IRQ_SOF = 1;
    localparam int UPR_IRQ_TOKEN = 2;
    localparam int UPR_IRQ_WIDTH = 3;
    localparam int UPR_ALIGN_BITS = 9;
    // **********************************************
    // Token codes and reset values
    // **********************************************
    localparam logic [3:0] UPR_PID_OUT = 4'h1;
    localparam logic [3:0] UPR_PID_IN = 4'h9;
    localparam logic [3:0] UPR_PID_SETUP = 4'hd;
    localparam logic [7:0] UPR_RESET_BYTE = 8'h00;
    localparam logic [2:0] UPR_RESET_FRAME = 3'h0;
    // Minimum time the core stays busy after power is dropped, in ns and in clock cycles
    localparam int UPR_SHUTDOWN_NS = 1000;
    localparam int UPR_CLK_NS = 25;
    localparam int UPR_SHUTDOWN_CYC = (UPR_SHUTDOWN_NS + UPR_CLK_NS - 1) / UPR_CLK_NS;

    typedef enum logic [1:0] {
        UPR_OFF = 2'b00,
        UPR_ON = 2'b01,
        UPR_DRAIN = 2'b10
    } upr_mode_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } upr_req_type;

    typedef struct packed {
        logic power;
        logic suspend;
        logic guard;
        logic [3:0] pid;
        logic [3:0] ep;
        logic [7:0] page_mid;
        logic [7:0] page_top;
        logic [2:0] frame;
        logic [UPR_IRQ_WIDTH-1:0] irq_status;
        logic [UPR_IRQ_WIDTH-1:0] irq_mask;
        upr_mode_type mode;
        logic [7:0] drain_cnt;
        logic [31:0] rdata;
        logic irq;
        logic token_go;
        logic clk48_en;
        logic xcvr_lowpower;
        logic pins_owned;
        logic sleep_block;
        logic [1:0] act_sync;
        logic [1:0] sof_sync;
        logic sof_seen;
    } upr_state_type;
endpackage
`default_nettype wire

// [verilog/upr_regs.sv]
// USB power control, frame number high, token and descriptor page registers.
// Assumes bus activity and start-of-frame come from the USB clock domain as levels/toggles.
// What this block does
// - Power bit switches module on or off
// - Disabled: 48 MHz clock and token outputs inactive, pins released, analog off
// - Suspend gates 48 MHz clock, transceiver low power
// - Busy reads 1 when active or draining
// - Guard blocks sleep on activity or any set interrupt status bit
// - Pending flag shows undelivered activity interrupt
// - Upper frame bits captured at each SOF while powered
// - Token codes OUT 0001, IN 1001, SETUP 1101
// - Mid page gives base bits 23-16
// - Top page gives base bits 31-24
// - Table base is 512-byte aligned
// - Upper 24 register bits read zero
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`default_nettype none
module upr_regs
    import upr_pkg::*;
#(
    parameter int SHUTDOWN_CYC = UPR_SHUTDOWN_CYC
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire upr_pkg::upr_req_type req,
    output logic [31:0] rdata,
    // USB core side
    input wire logic bus_activity,
    input wire logic sof_toggle,
    input wire logic [2:0] sof_frame_upper,
    input wire logic [6:0] base_bits_15_9,
    input wire logic core_idle,
    output logic module_enable,
    output logic clk48_enable,
    output logic xcvr_lowpower,
    output logic pins_owned,
    output logic token_start,
    output logic [3:0] token_pid,
    output logic [3:0] token_ep,
    output logic [31:0] descriptor_base,
    // System
    output logic sleep_block,
    output logic irq
);
    import upr_pkg::*;

    upr_state_type s_q;
    upr_state_type s_d;
    logic [31:0] base_q;
    logic [7:0] token_q;
    logic suspend_cycle;
    logic busy;
    logic pending;
    logic act_level;
    logic sof_pulse;
    logic [UPR_IRQ_WIDTH-1:0] events;

    // **********************************************
    // Next state
    // **********************************************
    always_comb
    begin
        s_d = s_q;
        s_d.act_sync = {s_q.act_sync[0], bus_activity};
        s_d.sof_sync = {s_q.sof_sync[0], sof_toggle};
        act_level = s_q.act_sync[1];
        sof_pulse = s_q.sof_sync[1] ^ s_q.sof_seen;
        s_d.sof_seen = s_q.sof_sync[1];
        busy = (s_q.mode != UPR_OFF);
        pending = s_q.irq_status[UPR_IRQ_ACTIVITY] & ~s_q.irq_mask[UPR_IRQ_ACTIVITY];
        events = '0;
        s_d.token_go = 1'b0;
        if (sof_pulse && s_q.power)
        begin
            s_d.frame = sof_frame_upper;
            events[UPR_IRQ_SOF] = 1'b1;
        end
        if (act_level && s_q.power)
        begin
            events[UPR_IRQ_ACTIVITY] = 1'b1;
        end
        case (s_q.mode)
            UPR_OFF:
            begin
                s_d.drain_cnt = '0;
                if (s_q.power)
                begin
                    s_d.mode = UPR_ON;
                end
            end
            UPR_ON:
            begin
                if (!s_q.power)
                begin
                    s_d.mode = UPR_DRAIN;
                    s_d.drain_cnt = '0;
                end
            end
            UPR_DRAIN:
            begin
                if (s_q.power)
                begin
                    s_d.mode = UPR_ON;
                end
                else if (s_q.drain_cnt >= 8'(SHUTDOWN_CYC - 1) && core_idle)
                begin
                    s_d.mode = UPR_OFF;
                end
                else if (s_q.drain_cnt < 8'(SHUTDOWN_CYC - 1))
                begin
                    s_d.drain_cnt = s_q.drain_cnt + 8'h01;
                end
            end
            default:
            begin
                s_d.mode = UPR_OFF;
            end
        endcase
        s_d.rdata = '0;
        if (req.wr)
        begin
            case (req.addr)
                UPR_OFF_POWER:
                begin
                    s_d.power = req.wdata[UPR_BIT_POWER];
                    s_d.suspend = req.wdata[UPR_BIT_SUSPEND];
                    s_d.guard = req.wdata[UPR_BIT_GUARD];
                end
                UPR_OFF_TOKEN:
                begin
                    s_d.pid = req.wdata[7:4];
                    s_d.ep = req.wdata[3:0];
                    s_d.token_go = s_q.power;
                    events[UPR_IRQ_TOKEN] = s_q.power;
                end
                UPR_OFF_PAGE_MID:
                begin
                    s_d.page_mid = req.wdata[7:0];
                end
                UPR_OFF_PAGE_TOP:
                begin
                    s_d.page_top = req.wdata[7:0];
                end
                UPR_OFF_IRQ_MASK:
                begin
                    s_d.irq_mask = req.wdata[UPR_IRQ_WIDTH-1:0];
                end
                default:
                begin
                end
            endcase
        end
        // Write-one-to-clear; a new event in the same cycle wins
        if (req.wr && req.addr == UPR_OFF_IRQ_STATUS)
        begin
            s_d.irq_status = (s_q.irq_status & ~req.wdata[UPR_IRQ_WIDTH-1:0]) | events;
        end
        else
        begin
            s_d.irq_status = s_q.irq_status | events;
        end
        if (req.rd)
        begin
            case (req.addr)
                UPR_OFF_POWER:
                begin
                    s_d.rdata[UPR_BIT_POWER] = s_q.power;
                    s_d.rdata[UPR_BIT_SUSPEND] = s_q.suspend;
                    s_d.rdata[UPR_BIT_BUSY] = busy;
                    s_d.rdata[UPR_BIT_GUARD] = s_q.guard;
                    s_d.rdata[UPR_BIT_PENDING] = pending;
                end
                UPR_OFF_FRAME:
                begin
                    s_d.rdata[2:0] = s_q.frame;
                end
                UPR_OFF_TOKEN:
                begin
                    s_d.rdata[7:0] = {s_q.pid, s_q.ep};
                end
                UPR_OFF_PAGE_MID:
                begin
                    s_d.rdata[7:0] = s_q.page_mid;
                end
                UPR_OFF_PAGE_TOP:
                begin
                    s_d.rdata[7:0] = s_q.page_top;
                end
                UPR_OFF_IRQ_STATUS:
                begin
                    s_d.rdata[UPR_IRQ_WIDTH-1:0] = s_q.irq_status;
                end
                UPR_OFF_IRQ_MASK:
                begin
                    s_d.rdata[UPR_IRQ_WIDTH-1:0] = s_q.irq_mask;
                end
                default:
                begin
                end
            endcase
        end
        s_d.irq = |(s_d.irq_status & s_d.irq_mask);
        // Disabled module releases pins and holds clocks off
        s_d.pins_owned = s_d.power;
        s_d.clk48_en = s_d.power & ~s_d.suspend;
        s_d.xcvr_lowpower = ~s_d.power | s_d.suspend;
        s_d.sleep_block = s_d.guard & (act_level | (|s_d.irq_status));
    end

    // **********************************************
    // State register
    // **********************************************
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_q <= '0;
            s_q.xcvr_lowpower <= 1'b1;
            base_q <= '0;
            token_q <= 8'h00;
        end
        else
        begin
            s_q <= s_d;
            // Low nine bits stay zero for alignment
            base_q <= {s_d.page_top, s_d.page_mid, base_bits_15_9, 9'h000};
            token_q <= s_d.power ? {s_d.pid, s_d.ep} : 8'h00;
        end
    end

    assign rdata = s_q.rdata;
    assign irq = s_q.irq;
    assign module_enable = s_q.power;
    assign clk48_enable = s_q.clk48_en;
    assign xcvr_lowpower = s_q.xcvr_lowpower;
    assign pins_owned = s_q.pins_owned;
    assign token_start = s_q.token_go;
    assign token_pid = token_q[7:4];
    assign token_ep = token_q[3:0];
    assign descriptor_base = base_q;
    assign sleep_block = s_q.sleep_block;

    // **********************************************
    // Assertions
    // **********************************************
    AST_POWER_OFF: assert property (@(posedge clk) disable iff (!reset_n)
        !module_enable |-> !pins_owned && !clk48_enable && xcvr_lowpower)
        else $error("Disabled module still drives");
    AST_SUSPEND: assert property (@(posedge clk) disable iff (!reset_n)
        suspend_cycle |-> !clk48_enable)
        else $error("Clock not gated in suspend");
    AST_ENABLE: assert property (@(posedge clk) disable iff (!reset_n)
        req.wr && req.addr == UPR_OFF_POWER && req.wdata[0] |=> module_enable)
        else $error("Power write ignored");
    AST_BUSY_ON: assert property (@(posedge clk) disable iff (!reset_n)
        module_enable |-> ##2 (s_q.mode != UPR_OFF) || !module_enable)
        else $error("Busy low while active");
    AST_GUARD: assert property (@(posedge clk) disable iff (!reset_n)
        sleep_block == (s_q.guard && (|s_q.irq_status || $past(s_q.act_sync[1]))))
        else $error("Sleep blocked without guard");
    AST_FRAME: assert property (@(posedge clk) disable iff (!reset_n)
        !$stable(s_q.frame) |-> $past(s_q.sof_sync[1] ^ s_q.sof_seen))
        else $error("Frame changed without SOF");
    AST_BASE_ALIGN: assert property (@(posedge clk) disable iff (!reset_n)
        descriptor_base[8:0] == 9'h000)
        else $error("Base not aligned");
    AST_PAGE: assert property (@(posedge clk) disable iff (!reset_n)
        req.wr && req.addr == UPR_OFF_PAGE_TOP |-> ##2 descriptor_base[31:24] == $past(req.wdata[7:0], 2))
        else $error("Top page not in base");
    AST_UPPER_ZERO: assert property (@(posedge clk) disable iff (!reset_n)
        rdata[31:8] == 24'h000000)
        else $error("Upper bits not zero");
    AST_PENDING: assert property (@(posedge clk) disable iff (!reset_n)
        req.rd && req.addr == UPR_OFF_POWER |=> rdata[7] == $past(pending))
        else $error("Pending flag wrong");
    AST_TOKEN_GO: assert property (@(posedge clk) disable iff (!reset_n)
        req.wr && req.addr == UPR_OFF_TOKEN && module_enable |=> token_start && token_pid == $past(req.wdata[7:4]) && token_ep == $past(req.wdata[3:0]))
        else $error("Token not launched");
    AST_TOKEN_IDLE: assert property (@(posedge clk) disable iff (!reset_n)
        !module_enable |=> !token_start)
        else $error("Token launched while off");
    AST_BUSY_READ: assert property (@(posedge clk) disable iff (!reset_n)
        req.rd && req.addr == UPR_OFF_POWER && module_enable && $past(module_enable) |=> rdata[3] && rdata[0])
        else $error("Busy not shown while on");
    AST_FRAME_CAPTURE: assert property (@(posedge clk) disable iff (!reset_n)
        module_enable && (s_q.sof_sync[1] != s_q.sof_seen) |=> s_q.frame == $past(sof_frame_upper))
        else $error("Frame not captured at SOF");
    AST_CLK_ON: assert property (@(posedge clk) disable iff (!reset_n)
        module_enable && !suspend_cycle |-> clk48_enable && !xcvr_lowpower)
        else $error("Clock off while running");
    AST_UNMAPPED: assert property (@(posedge clk) disable iff (!reset_n)
        req.rd && req.addr > UPR_OFF_IRQ_MASK |=> rdata == 32'h00000000)
        else $error("Unmapped read not zero");

    assign suspend_cycle = s_q.suspend;
endmodule
`default_nettype wire

// [test/upr_usb_model.sv]
// Behavioural USB core side facing the register slice.
// Assumes the bench commands activity and start-of-frame events.
`default_nettype none
module upr_usb_model
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // From the slice
    input wire logic pins_owned,
    input wire logic clk48_enable,
    // From the bench
    input wire logic act_cmd,
    input wire logic sof_cmd,
    input wire logic [2:0] frame_cmd,
    // To the slice
    output logic bus_activity,
    output logic sof_toggle,
    output logic [2:0] sof_frame_upper,
    output logic [6:0] base_bits_15_9,
    output logic core_idle
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] idle_cnt_q;
    assign bus_activity = act_cmd & pins_owned;
    assign base_bits_15_9 = 7'h55;
    assign core_idle = !pins_owned && idle_cnt_q == 3'h0;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            idle_cnt_q <= 3'h0;
            sof_toggle <= 1'b0;
            sof_frame_upper <= 3'h0;
        end
        else
        begin
            if (pins_owned)
                idle_cnt_q <= 3'h7;
            else if (idle_cnt_q != 3'h0)
                idle_cnt_q <= idle_cnt_q - 3'h1;
            if (sof_cmd && clk48_enable)
            begin
                sof_frame_upper <= frame_cmd;
                sof_toggle <= ~sof_toggle;
            end
        end
    end
endmodule
`default_nettype wire

// [test/upr_regs_bench.sv]
// Self-checking bench for the power, frame, token and page slice.
// Assumes the core model in upr_usb_model and a 40 MHz clock.
`default_nettype none
module upr_regs_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import upr_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    upr_req_type req = '0;
    logic act_cmd = 1'b0;
    logic sof_cmd = 1'b0;
    logic [2:0] frame_cmd = 3'h0;
    logic [31:0] rdata, descriptor_base;
    logic bus_activity, sof_toggle, core_idle, module_enable, clk48_enable;
    logic xcvr_lowpower, pins_owned, token_start, sleep_block, irq;
    logic [2:0] sof_frame_upper;
    logic [6:0] base_bits_15_9;
    logic [3:0] token_pid, token_ep;
    int miscompares = 0;
    int cmp_count = 0;
    always #12.5 clk = ~clk;
    upr_usb_model core (.clk(clk), .reset_n(reset_n), .pins_owned(pins_owned), .clk48_enable(clk48_enable),
        .act_cmd(act_cmd), .sof_cmd(sof_cmd), .frame_cmd(frame_cmd), .bus_activity(bus_activity),
        .sof_toggle(sof_toggle), .sof_frame_upper(sof_frame_upper), .base_bits_15_9(base_bits_15_9),
        .core_idle(core_idle));
    upr_regs #(.SHUTDOWN_CYC(2)) dut (.clk(clk), .reset_n(reset_n), .req(req), .rdata(rdata),
        .bus_activity(bus_activity), .sof_toggle(sof_toggle), .sof_frame_upper(sof_frame_upper),
        .base_bits_15_9(base_bits_15_9), .core_idle(core_idle), .module_enable(module_enable),
        .clk48_enable(clk48_enable), .xcvr_lowpower(xcvr_lowpower), .pins_owned(pins_owned),
        .token_start(token_start), .token_pid(token_pid), .token_ep(token_ep),
        .descriptor_base(descriptor_base), .sleep_block(sleep_block), .irq(irq));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            $display("[ERR] %s exp %h got %h", n, e, g);
            miscompares++;
        end
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        chk(n, e, rdata);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic sof(input logic [2:0] f);
        @(posedge clk);
        frame_cmd <= f;
        sof_cmd <= 1'b1;
        @(posedge clk);
        sof_cmd <= 1'b0;
        settle(6);
    endtask
    task automatic set_act(input logic v);
        @(posedge clk);
        act_cmd <= v;
        settle(6);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        #1;
        chk("rst_outs", 32'h8, {module_enable, pins_owned, clk48_enable, xcvr_lowpower, token_start, irq, sleep_block});
        for (int i = 0; i < 8; i++)
            rd_chk("rst_rd", 8'(i * 4), 32'h0);
        chk("rst_base", 32'h0000_aa00, descriptor_base);
    endtask
    task automatic t_power;
        bus_wr(UPR_OFF_POWER, 32'h1);
        settle(1);
        chk("on", 32'he, {module_enable, pins_owned, clk48_enable, xcvr_lowpower});
        rd_chk("pwr_on", UPR_OFF_POWER, 32'h9);
        bus_wr(UPR_OFF_POWER, 32'hffff_ff03);
        settle(1);
        chk("susp", 32'hd, {module_enable, pins_owned, clk48_enable, xcvr_lowpower});
        rd_chk("pwr_susp", UPR_OFF_POWER, 32'hb);
        bus_wr(UPR_OFF_POWER, 32'h1);
        settle(1);
        chk("resume", 32'he, {module_enable, pins_owned, clk48_enable, xcvr_lowpower});
    endtask
    task automatic t_token;
        logic [3:0] pids [3] = '{UPR_PID_OUT, UPR_PID_IN, UPR_PID_SETUP};
        for (int i = 0; i < 3; i++)
        begin
            bus_wr(UPR_OFF_TOKEN, {24'hffffff, pids[i], 4'(3 + 5 * i)});
            #1;
            chk("tok_go", 32'h1, token_start);
            settle(1);
            chk("tok_pulse", 32'h0, token_start);
            chk("tok_out", {pids[i], 4'(3 + 5 * i)}, {token_pid, token_ep});
            rd_chk("tok_rd", UPR_OFF_TOKEN, {pids[i], 4'(3 + 5 * i)});
        end
    endtask
    task automatic t_pages;
        bus_wr(UPR_OFF_PAGE_MID, 32'hffff_ffa5);
        bus_wr(UPR_OFF_PAGE_TOP, 32'h1234_565a);
        settle(2);
        chk("base", 32'h5aa5_aa00, descriptor_base);
        rd_chk("mid_rd", UPR_OFF_PAGE_MID, 32'ha5);
        rd_chk("top_rd", UPR_OFF_PAGE_TOP, 32'h5a);
        bus_wr(8'h1c, 32'hff);
        rd_chk("unmapped", 8'h1c, 32'h0);
    endtask
    task automatic t_irq;
        bus_wr(UPR_OFF_IRQ_STATUS, 32'h7);
        bus_wr(UPR_OFF_IRQ_MASK, 32'h2);
        rd_chk("mask_rd", UPR_OFF_IRQ_MASK, 32'h2);
        for (int i = 0; i < 2; i++)
        begin
            sof(i == 0 ? 3'h5 : 3'h2);
            chk("irq_sof", 32'h1, irq);
            rd_chk("frame", UPR_OFF_FRAME, i == 0 ? 32'h5 : 32'h2);
            bus_wr(UPR_OFF_IRQ_STATUS, 32'h2);
            settle(1);
            chk("irq_clr", 32'h0, irq);
        end
        bus_wr(UPR_OFF_IRQ_MASK, 32'h0);
        sof(3'h7);
        chk("irq_masked", 32'h0, irq);
        rd_chk("stat_sof", UPR_OFF_IRQ_STATUS, 32'h2);
        bus_wr(UPR_OFF_IRQ_STATUS, 32'h2);
    endtask
    task automatic t_activity;
        bus_wr(UPR_OFF_POWER, 32'h11);
        settle(1);
        chk("grd_idle", 32'h0, sleep_block);
        set_act(1'b1);
        chk("grd_act", 32'h1, sleep_block);
        rd_chk("pending", UPR_OFF_POWER, 32'h99);
        set_act(1'b0);
        bus_wr(UPR_OFF_IRQ_STATUS, 32'h1);
        settle(2);
        chk("grd_clr", 32'h0, sleep_block);
        rd_chk("no_pend", UPR_OFF_POWER, 32'h19);
        bus_wr(UPR_OFF_POWER, 32'h1);
        set_act(1'b1);
        chk("no_guard", 32'h0, sleep_block);
        bus_wr(UPR_OFF_IRQ_MASK, 32'h1);
        settle(2);
        chk("irq_act", 32'h1, irq);
        rd_chk("delivered", UPR_OFF_POWER, 32'h9);
        set_act(1'b0);
        bus_wr(UPR_OFF_IRQ_STATUS, 32'h1);
        settle(2);
        chk("irq_act_clr", 32'h0, irq);
    endtask
    task automatic t_off;
        bus_wr(UPR_OFF_POWER, 32'h0);
        #1;
        chk("off", 32'h1, {module_enable, pins_owned, clk48_enable, xcvr_lowpower});
        chk("tok_off", 32'h0, {token_pid, token_ep});
        rd_chk("busy_drain", UPR_OFF_POWER, 32'h8);
        settle(20);
        rd_chk("busy_idle", UPR_OFF_POWER, 32'h0);
        bus_wr(UPR_OFF_TOKEN, {24'h0, UPR_PID_IN, 4'h2});
        #1;
        chk("tok_unpowered", 32'h0, token_start);
    endtask
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        t_reset;
        t_power;
        t_token;
        t_pages;
        t_irq;
        t_activity;
        t_off;
        print_verdict;
    end
    initial
    begin
        #50us;
        miscompares++;
        print_verdict;
    end
endmodule
`default_nettype wire
